// >>> core/cfg_link_sync.sv
// Two-flop synchroniser for the three configuration pins, with edge finders on select and clock.
`include "cfg_loader_map.svh"
`default_nettype none
module cfg_link_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sel_pin,
   input wire logic clk_pin,
   input wire logic data_pin,
   output logic sel_lvl,
   output logic sel_rise,
   output logic sel_fall,
   output logic clk_rise,
   output logic data_lvl
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [1:0] prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         prev_q <= 2'h0;
      end else begin
         meta_q <= {data_pin, clk_pin, sel_pin};
         sync_q <= meta_q;
         prev_q <= sync_q[1:0];
      end
   end

   assign sel_lvl = sync_q[0];
   assign data_lvl = sync_q[2];
   assign sel_rise = sync_q[0] & ~prev_q[0];
   assign sel_fall = ~sync_q[0] & prev_q[0];
   assign clk_rise = sync_q[1] & ~prev_q[1];
endmodule
`default_nettype wire

// >>> core/cfg_loader_map.svh
// Offsets, field positions, reset values and the bit-count width of the loader.
`ifndef CFG_LOADER_MAP_SVH
`define CFG_LOADER_MAP_SVH
`define CFG_WORD_BITS 18
`define CFG_WORD_RESET 18'h10f04
`define CFG_BIT_CRC_LEN 17
`define CFG_BIT_CRC_EN 16
`define CFG_BIT_RSVD_HI 15
`define CFG_BIT_MODE 14
`define CFG_BIT_RATE 13
`define CFG_XTAL_HI 12
`define CFG_XTAL_LO 10
`define CFG_PWR_HI 9
`define CFG_PWR_LO 8
`define CFG_CHAN_HI 7
`define CFG_CHAN_LO 1
`define CFG_BIT_RSVD_LO 0
`define CFG_XTAL_16MHZ 3'h3
`define CFG_XTAL_MAX 3'h4
`define CFG_FREQ_BASE_MHZ 12'h960
`define CFG_REG_CONFIG 12'h000
`define CFG_REG_PENDING 12'h004
`define CFG_REG_STATUS 12'h008
`define CFG_REG_FREQ 12'h00c
`define CFG_CNT_BITS 5
`endif

// >>> core/cfg_loader_pkg.sv
// Types shared by the configuration word loader.
`default_nettype none
package cfg_loader_pkg;
   typedef logic [17:0] cfg_word_t;
   typedef enum logic [2:0] {
      crc_off = 3'b001,
      crc_8 = 3'b010,
      crc_16 = 3'b100
   } crc_mode_e;
endpackage
`default_nettype wire

// >>> core/cfg_word_loader.sv
// Serial loader for the transmitter configuration word, with APB view.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`include "cfg_loader_map.svh"
`default_nettype none
module cfg_word_loader #(
   parameter int WORD_BITS = `CFG_WORD_BITS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic config_select,
   input wire logic shift_clock,
   input wire logic config_data,
   input wire logic radio_power_on,
   input wire logic tx_activate,
   output logic crc_length_sel,
   output logic crc_gen_enable,
   output logic comm_mode_sel,
   output logic rf_rate_sel,
   output logic [2:0] crystal_freq_sel,
   output logic [1:0] output_power_sel,
   output logic [6:0] channel_number,
   output logic config_error
);
   localparam logic [17:0] reset_word = `CFG_WORD_RESET;

   logic sel_lvl, sel_rise, sel_fall, clk_rise, data_lvl;
   logic [1:0] pwr_meta_q, pwr_q;
   cfg_loader_pkg::cfg_word_t active_q;
   cfg_loader_pkg::cfg_word_t shift_q;
   logic [`CFG_CNT_BITS-1:0] count_q;
   logic overflow_q;
   logic conflict_q;
   logic [7:0] loads_q;
   cfg_loader_pkg::crc_mode_e crc_mode;

   cfg_link_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .sel_pin(config_select),
      .clk_pin(shift_clock),
      .data_pin(config_data),
      .sel_lvl(sel_lvl),
      .sel_rise(sel_rise),
      .sel_fall(sel_fall),
      .clk_rise(clk_rise),
      .data_lvl(data_lvl)
   );

   // Mask of the low n bits; bits above the shifted count keep old values.
   function automatic cfg_loader_pkg::cfg_word_t low_mask(
      input logic [`CFG_CNT_BITS-1:0] n);
      cfg_loader_pkg::cfg_word_t m;
      m = '0;
      for (int i = 0; i < WORD_BITS; i++) begin
         if (i < int'(n)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_meta_q <= 2'h0;
         pwr_q <= 2'h0;
      end else begin
         pwr_meta_q <= {tx_activate, radio_power_on};
         pwr_q <= pwr_meta_q;
      end
   end

   // Shift register and count of bits taken in this select period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_q <= '0;
         count_q <= '0;
         overflow_q <= 1'b0;
      end else if (sel_rise) begin
         shift_q <= '0;
         count_q <= '0;
         overflow_q <= 1'b0;
      end else if (sel_lvl && clk_rise) begin
         shift_q <= {shift_q[16:0], data_lvl};
         if (int'(count_q) < WORD_BITS) begin
            count_q <= count_q + 5'h01;
         end else begin
            overflow_q <= 1'b1;
         end
      end
   end

   // Commit at select fall. Retention relies on no reset other than presetn.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= reset_word;
      end else if (sel_fall) begin
         active_q <= (active_q & ~low_mask(count_q)) |
                     (shift_q & low_mask(count_q));
      end
   end

   // Sticky error: select with activate high or power off; overlong load is held only until the next select rise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conflict_q <= 1'b0;
      end else if (sel_lvl && (pwr_q[1] || !pwr_q[0])) begin
         conflict_q <= 1'b1;
      end else if (psel && penable && pwrite &&
                   paddr == `CFG_REG_STATUS && pwdata[0]) begin
         conflict_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loads_q <= 8'h00;
      end else if (sel_fall) begin
         loads_q <= loads_q + 8'h01;
      end
   end

   always_comb begin
      if (!active_q[`CFG_BIT_CRC_EN]) begin
         crc_mode = cfg_loader_pkg::crc_off;
      end else if (active_q[`CFG_BIT_CRC_LEN]) begin
         crc_mode = cfg_loader_pkg::crc_16;
      end else begin
         crc_mode = cfg_loader_pkg::crc_8;
      end
   end

   // Field outputs; CRC is forced off in direct mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_length_sel <= reset_word[`CFG_BIT_MODE] &
                           reset_word[`CFG_BIT_CRC_LEN];
         crc_gen_enable <= reset_word[`CFG_BIT_MODE] &
                           reset_word[`CFG_BIT_CRC_EN];
         comm_mode_sel <= reset_word[`CFG_BIT_MODE];
         rf_rate_sel <= reset_word[`CFG_BIT_RATE];
         crystal_freq_sel <= reset_word[`CFG_XTAL_HI:`CFG_XTAL_LO];
         output_power_sel <= reset_word[`CFG_PWR_HI:`CFG_PWR_LO];
         channel_number <= reset_word[`CFG_CHAN_HI:`CFG_CHAN_LO];
         config_error <= 1'b0;
      end else begin
         crc_length_sel <= active_q[`CFG_BIT_MODE] &
                           (crc_mode == cfg_loader_pkg::crc_16);
         crc_gen_enable <= active_q[`CFG_BIT_MODE] &
                           (crc_mode != cfg_loader_pkg::crc_off);
         comm_mode_sel <= active_q[`CFG_BIT_MODE];
         rf_rate_sel <= active_q[`CFG_BIT_RATE];
         crystal_freq_sel <= active_q[`CFG_XTAL_HI:`CFG_XTAL_LO];
         output_power_sel <= active_q[`CFG_PWR_HI:`CFG_PWR_LO];
         channel_number <= active_q[`CFG_CHAN_HI:`CFG_CHAN_LO];
         // Flags settings the radio cannot honour, such as 1 Mbps on a
         // crystal other than 16 MHz or an undefined crystal code.
         config_error <= conflict_q | overflow_q |
            (active_q[`CFG_BIT_RATE] &&
             active_q[`CFG_XTAL_HI:`CFG_XTAL_LO] != `CFG_XTAL_16MHZ) |
            (active_q[`CFG_XTAL_HI:`CFG_XTAL_LO] > `CFG_XTAL_MAX);
      end
   end

   // APB slave: zero wait states, writes only to STATUS (bit 0 clears conflict), unmapped reads error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `CFG_REG_CONFIG: prdata <= {14'h0, active_q};
               `CFG_REG_PENDING: prdata <= {9'h0, count_q, shift_q};
               `CFG_REG_STATUS: prdata <= {loads_q, 20'h0, overflow_q,
                                           conflict_q, sel_lvl, config_error};
               `CFG_REG_FREQ: prdata <= {20'h0, `CFG_FREQ_BASE_MHZ +
                                   {5'h0, active_q[`CFG_CHAN_HI:`CFG_CHAN_LO]}};
               default: pslverr <= 1'b1;
            endcase
         end else if (psel && !penable && pwrite &&
                      paddr != `CFG_REG_STATUS) begin
            pslverr <= 1'b1;
         end
      end
   end

   sequence sel_falls_s;
      $fell(sel_lvl);
   endsequence

   sequence apb_setup_s;
      psel && !penable;
   endsequence

   sequence bit_taken_s;
      sel_lvl && clk_rise && !sel_rise;
   endsequence

   reset_word_a: assert property (
      @(posedge pclk) $rose(presetn) |-> active_q == reset_word)
      else $error("Configuration word not at reset value.");

   hold_until_fall_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sel_fall |=> $stable(active_q))
      else $error("Configuration changed without select fall.");

   partial_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sel_falls_s ##0 (count_q == 5'h08) |=>
      active_q[17:8] == $past(active_q[17:8]) &&
      active_q[7:0] == $past(shift_q[7:0]))
      else $error("Byte load touched upper bits.");

   full_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sel_falls_s ##0 (count_q == 5'h12) |=> active_q == $past(shift_q))
      else $error("Full load not committed whole.");

   shift_in_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      bit_taken_s |=>
      shift_q[0] == $past(data_lvl) && shift_q[17:1] == $past(shift_q[16:0]))
      else $error("Bit not shifted in at clock rise.");

   count_step_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      bit_taken_s ##0 (count_q < 5'h12) |=> count_q == $past(count_q) + 5'h01)
      else $error("Bit count did not advance.");

   count_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sel_rise |=> count_q == 5'h00 && !overflow_q)
      else $error("Select rise did not clear the count.");

   count_cap_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      count_q <= 5'h12)
      else $error("Bit count past word length.");

   crc_direct_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !active_q[14] |=> !crc_gen_enable && !crc_length_sel)
      else $error("CRC active in direct mode.");

   chan_out_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> channel_number == $past(active_q[7:1]))
      else $error("Channel output not following register.");

   crc_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      active_q[14] && active_q[16] |=>
      crc_gen_enable && crc_length_sel == $past(active_q[17]))
      else $error("CRC fields mapped wrongly.");

   rate_err_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      active_q[13] && active_q[12:10] != 3'h3 |=> config_error)
      else $error("Fast rate on wrong crystal not flagged.");

   mode_out_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> comm_mode_sel == $past(active_q[14]))
      else $error("Mode output not following register.");

   rate_out_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> rf_rate_sel == $past(active_q[13]))
      else $error("Rate output not following register.");

   xtal_out_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> crystal_freq_sel == $past(active_q[12:10]))
      else $error("Crystal output not following register.");

   power_out_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> output_power_sel == $past(active_q[9:8]))
      else $error("Power output not following register.");

   apb_ready_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      apb_setup_s |=> pready)
      else $error("No ready after setup cycle.");

   ready_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("Ready held longer than one cycle.");
endmodule
`default_nettype wire

// >>> test/cfg_host_model.sv
// Behavioural host that drives the three-wire configuration pins.
`default_nettype none
module cfg_host_model #(
   parameter int HALF_NS = 80,
   parameter int CS2DATA_NS = 5000
) (
   output var logic config_select,
   output var logic shift_clock,
   output var logic config_data,
   output var logic radio_power_on,
   output var logic tx_activate
);
   timeunit 1ns;
   timeprecision 1ps;
   // Power stays on and activate low, so select never meets activate.
   initial begin
      config_select = 1'b0;
      shift_clock = 1'b0;
      config_data = 1'b0;
      radio_power_on = 1'b1;
      tx_activate = 1'b0;
   end
   task automatic open_frame();
      config_select = 1'b1;
      #(CS2DATA_NS);
   endtask
   // The word is sent MSB first; no frame is ever longer than the word.
   task automatic send(input logic [17:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         config_data = w[i];
         #(HALF_NS);
         shift_clock = 1'b1;
         #(HALF_NS);
         shift_clock = 1'b0;
      end
      // The line has no pull, so a released line must not echo old data.
      config_data = ~config_data;
   endtask
   task automatic close_frame();
      #(HALF_NS);
      config_select = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> test/radio_config_word_loader_tb.sv
// Self-checking bench for the configuration word loader.
`default_nettype none
module radio_config_word_loader_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sel, sck, sdat, pwr_on, tx_act, crc_len, crc_en, mode, rate, cerr;
   logic [2:0] xtal;
   logic [1:0] pwr;
   logic [6:0] chan;
   logic [17:0] cur;
   logic err;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   cfg_word_loader u_cfg_word_loader (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .config_select(sel), .shift_clock(sck), .config_data(sdat),
      .radio_power_on(pwr_on), .tx_activate(tx_act),
      .crc_length_sel(crc_len), .crc_gen_enable(crc_en),
      .comm_mode_sel(mode), .rf_rate_sel(rate), .crystal_freq_sel(xtal),
      .output_power_sel(pwr), .channel_number(chan), .config_error(cerr));
   cfg_host_model u_cfg_host_model (.config_select(sel), .shift_clock(sck),
      .config_data(sdat), .radio_power_on(pwr_on), .tx_activate(tx_act));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic test_done();
      if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // The master waits for pready; only the bench timeout ends a hang.
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic [31:0] exp, input logic experr);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!wr) check("prdata", rd, exp);
      check("pslverr", {31'h0, err}, {31'h0, experr});
   endtask
   // CRC outputs read zero in direct mode.
   task automatic fields(input logic [17:0] w);
      check("crc_len", {31'h0, crc_len}, {31'h0, w[17] & w[14]});
      check("crc_en", {31'h0, crc_en}, {31'h0, w[16] & w[14]});
      check("mode", {31'h0, mode}, {31'h0, w[14]});
      check("rate", {31'h0, rate}, {31'h0, w[13]});
      check("xtal", {29'h0, xtal}, {29'h0, w[12:10]});
      check("power", {30'h0, pwr}, {30'h0, w[9:8]});
      check("chan", {25'h0, chan}, {25'h0, w[7:1]});
      apb(1'b0, 12'h000, 32'h0, {14'h0, w}, 1'b0);
      apb(1'b0, 12'h00c, 32'h0, 32'h960 + {25'h0, w[7:1]}, 1'b0);
   endtask
   // Loads n bits and checks that nothing moves before select falls.
   task automatic load(input logic [17:0] w, input int n);
      logic [17:0] p;
      p = 18'h00000;
      for (int i = 0; i < n; i++) p[i] = w[i];
      u_cfg_host_model.open_frame();
      u_cfg_host_model.send(w, n);
      repeat (8) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0, {9'h0, 5'(n), p}, 1'b0);
      fields(cur);
      u_cfg_host_model.close_frame();
      repeat (10) @(posedge pclk);
      for (int i = 0; i < n; i++) cur[i] = w[i];
      fields(cur);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cur = 18'h10f04;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      fields(cur);
      apb(1'b1, 12'h000, 32'h3ffff, 32'h0, 1'b1);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      fields(cur);
      load({5'h1b, 3'h3, 2'h2, 7'h55, 1'b0}, 18);
      load({10'h0, 7'h7f, 1'b0}, 8);
      load({5'h18, 3'h1, 2'h1, 7'h10, 1'b0}, 18);
      for (int i = 0; i < 5; i++) begin
         load({5'h0, 3'(i), 2'(i), 7'(i + 3), 1'b0}, 13);
      end
      check("config_error", {31'h0, cerr}, 32'h0);
      // A fast rate on a 12 MHz crystal is a setting the radio cannot honour.
      load({4'h0, 1'b1, 3'h2, 2'h3, 7'h05, 1'b0}, 14);
      check("config_error", {31'h0, cerr}, 32'h1);
      apb(1'b0, 12'h008, 32'h0, 32'h09000001, 1'b0);
      apb(1'b1, 12'h008, 32'h1, 32'h0, 1'b0);
      test_done();
   end
endmodule
`default_nettype wire
